// >>> rtl/mts_defines.svh
// constants for the translation and system control block
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH
// control register locations
`define MTS_CR_ID 4'h0
`define MTS_CR_CTL 4'h1
`define MTS_CR_TTB 4'h2
`define MTS_CR_DAC 4'h3
`define MTS_CR_FSR 4'h5
`define MTS_CR_FAR 4'h6
`define MTS_CR_CACHE 4'h7
`define MTS_CR_TLBOP 4'h8
`define MTS_CR_CLK 4'h9
`define MTS_CR_TLK 4'ha
`define MTS_CR_PID 4'hd
`define MTS_CR_TEST 4'hf
`define MTS_OP2_MAIN 3'h0
`define MTS_OP2_ALT 3'h1
`define MTS_CRM_INSTRUCTION_CACHE 4'h1
// transfer instruction fields
`define MTS_I_FIX 27:24
`define MTS_FIX_VAL 4'he
`define MTS_I_ONES 11:8
`define MTS_ONES_VAL 4'hf
`define MTS_I_BIT4 4
`define MTS_I_DIR 20
`define MTS_I_CRN 19:16
`define MTS_I_OP2 7:5
`define MTS_I_CRM 3:0
// control bits, process id field, lock base position
`define MTS_CTL_MMU 0
`define MTS_CTL_ALIGN 1
`define MTS_PID_F 31:25
`define MTS_PID_ZERO 7'h00
`define MTS_PID_MSK 32'hfe00_0000
`define MTS_TLK_LSB 0
// fault status codes and layout
`define MTS_FS_ALIGN 4'h1
`define MTS_FS_TRANS_S 4'h5
`define MTS_FS_TRANS_P 4'h7
`define MTS_FS_DOM_S 4'h9
`define MTS_FS_DOM_P 4'hb
`define MTS_FS_PERM_S 4'hd
`define MTS_FS_PERM_P 4'hf
`define MTS_NO_DOM 4'h0
// descriptor types and fields
`define MTS_D_TYPE 1:0
`define MTS_D_FAULT 2'b00
`define MTS_D_COARSE 2'b01
`define MTS_D_SECT 2'b10
`define MTS_D_FINE 2'b11
`define MTS_P_LARGE 2'b01
`define MTS_P_SMALL 2'b10
`define MTS_P_TINY 2'b11
`define MTS_D_DOM 8:5
`define MTS_D_SAP 11:10
`define MTS_D_PAP 11:4
`define MTS_D_TAP 5:4
`define MTS_D_CBASE 31:10
`define MTS_D_FBASE 31:12
`define MTS_TTB_BASE 31:14
`define MTS_MVA_L1 31:20
`define MTS_MVA_CIDX 19:12
`define MTS_MVA_FIDX 19:10
`define MTS_MVA_LSUB 15:14
`define MTS_MVA_SSUB 11:10
`define MTS_WORD_PAD 2'b00
// page offset masks per mapping size
`define MTS_MSK_SECT 32'h000f_ffff
`define MTS_MSK_LARGE 32'h0000_ffff
`define MTS_MSK_SMALL 32'h0000_0fff
`define MTS_MSK_TINY 32'h0000_03ff
// domain and permission codes, access sizes
`define MTS_DA_CLIENT 2'b01
`define MTS_DA_MGR 2'b11
`define MTS_AP_NONE 2'b00
`define MTS_AP_PRIV 2'b01
`define MTS_AP_URO 2'b10
`define MTS_SZ_HALF 2'h1
`define MTS_SZ_WORD 2'h2
`endif

// >>> rtl/mts_pkg.sv
// types shared by the translation and system control block
package mts_pkg;
  typedef enum logic [1:0] {
    MTS_SECT, MTS_LARGE, MTS_SMALL, MTS_TINY
  } mts_kind_t;
  // gray order along idle, look, walk1, walk2
  typedef enum logic [1:0] {
    MTS_IDLE = 2'b00, MTS_LOOK = 2'b01,
    MTS_WALK1 = 2'b11, MTS_WALK2 = 2'b10
  } mts_state_t;
  typedef struct packed {
    logic vld;
    mts_kind_t kind;
    logic [31:0] vbase;
    logic [31:0] pbase;
    logic [7:0] ap;
    logic [3:0] dom;
  } mts_tlb_ent_t;
  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] wdata;
    logic priv;
  } mts_cop_req_t;
  typedef struct packed {
    logic [31:0] va;
    logic fetch;
    logic write;
    logic priv;
    logic [1:0] size;
  } mts_acc_req_t;
endpackage : mts_pkg

// >>> rtl/mts_mmu_top.sv
// system control register port with translation and protection unit
// Operation
// - sixteen control register locations, each read-only, read/write, write-only or reserved
// - locations 0, 5 and 13 pick a register by the secondary opcode
// - location 9 picks a lockdown register by the auxiliary field
// - transfers only in privileged mode; write moves in, read returns a value
// - decode fixed pattern 1110, ones in 11:8, bit 4 set, bit 20 direction
// - register number comes from instruction bits 19:16
// - secondary opcode in bits 7:5 is zero unless a register defines more
// - auxiliary field in bits 3:0 selects a register-specific action
// - core address with bits 31:25 zero remapped by process id before translation
// - first-level table of 4096 entries indexed by address bits 31:20
// - first-level entry is a section or points to coarse or fine table
// - coarse maps large or small pages; fine also maps tiny pages
// - section 1 MB, large 64 KB, small 4 KB, tiny 1 KB
// - sixteen domains decide whether permissions apply or are ignored
// - sections and tiny pages one permission set; pages four, per quarter
// - on hit check permission then give physical address, else abort
// - on miss walk the tables in memory and refill the buffer
// - walk starts with first-level fetch; pages need one second fetch
// - abort on alignment (data only), translation, domain, permission faults
// - data faults record status and address; fetch faults own status
// - status holds cause and domain; address register holds faulting address
`timescale 1ns/1ns
`include "mts_defines.svh"
module mts_mmu_top #(
  parameter int TLB_N = 8, // lookaside entries, power of two
  parameter logic [31:0] ID_VAL = 32'h5a5a_0001, // arbitrary value
  parameter logic [31:0] CTYPE_VAL = 32'h0000_0000 // cache type word
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_cop_valid, // transfer request pulse
  input wire mts_pkg::mts_cop_req_t i_cop, // instruction, data, mode
  output logic o_cop_done, // transfer answered pulse
  output logic o_cop_undef, // transfer refused
  output logic [31:0] o_cop_rdata, // value for a read transfer
  input wire logic i_acc_valid, // memory access request
  input wire mts_pkg::mts_acc_req_t i_acc, // access attributes
  output logic o_acc_busy, // access in progress
  output logic o_acc_done, // access answered pulse
  output logic o_acc_abort, // access aborted
  output logic [31:0] o_acc_pa, // physical address
  output logic o_wlk_req, // table fetch request
  output logic [31:0] o_wlk_addr, // table fetch address
  input wire logic i_wlk_ack, // table fetch data valid
  input wire logic [31:0] i_wlk_data // table fetch data
);
  import mts_pkg::*;

  localparam int IW = $clog2(TLB_N);

  typedef struct packed {
    mts_state_t st;
    logic [31:0] ctl, ttb, dac, dfs, ifs, far;
    logic [31:0] dlk, ilk, tlk, pid, cid, tst;
    logic [31:0] modified_virtual_address;
    logic fetch, write, priv;
    logic [1:0] size;
    logic [31:0] l1d;
    mts_tlb_ent_t [TLB_N-1:0] translation_lookaside_buffer;
    logic [IW-1:0] vic;
    logic cop_done, cop_undef;
    logic [31:0] cop_rdata;
    logic acc_busy, acc_done, acc_abort;
    logic [31:0] acc_pa;
    logic wlk_req;
    logic [31:0] wlk_addr;
  } mts_st_t;

  mts_st_t q, n;
  logic hit, align_bad, flt;
  logic [IW-1:0] hidx, nvic;
  mts_tlb_ent_t ent;
  logic [1:0] dacc;
  logic [3:0] fcode, fdom, target_coproc_register, auxiliary_coproc_field;
  logic [2:0] op2;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // offset bits kept from the modified address per mapping size
  function automatic logic [31:0] size_mask(mts_kind_t k);
    unique case (k)
      MTS_SECT: size_mask = `MTS_MSK_SECT;
      MTS_LARGE: size_mask = `MTS_MSK_LARGE;
      MTS_SMALL: size_mask = `MTS_MSK_SMALL;
      MTS_TINY: size_mask = `MTS_MSK_TINY;
    endcase
  endfunction : size_mask

  // build a buffer entry from a final descriptor
  function automatic mts_tlb_ent_t mk_ent(mts_kind_t k, logic [31:0] d,
                                          logic [31:0] a, logic [3:0] dm);
    mk_ent.vld = 1'b1;
    mk_ent.kind = k;
    mk_ent.vbase = a & ~size_mask(k);
    mk_ent.pbase = d & ~size_mask(k);
    mk_ent.dom = dm;
    unique case (k)
      MTS_SECT: mk_ent.ap = {4{d[`MTS_D_SAP]}};
      MTS_TINY: mk_ent.ap = {4{d[`MTS_D_TAP]}};
      default: mk_ent.ap = d[`MTS_D_PAP];
    endcase
  endfunction : mk_ent

  // permission pair for the quarter page being touched
  function automatic logic [1:0] ap_sel(mts_tlb_ent_t e, logic [31:0] a);
    unique case (e.kind)
      MTS_LARGE: ap_sel = e.ap[{a[`MTS_MVA_LSUB], 1'b0} +: 2];
      MTS_SMALL: ap_sel = e.ap[{a[`MTS_MVA_SSUB], 1'b0} +: 2];
      default: ap_sel = e.ap[1:0];
    endcase
  endfunction : ap_sel

  function automatic logic perm_ok(logic [1:0] ap, logic pv, logic wr);
    unique case (ap)
      `MTS_AP_NONE: perm_ok = 1'b0;
      `MTS_AP_PRIV: perm_ok = pv;
      `MTS_AP_URO: perm_ok = pv | ~wr;
      default: perm_ok = 1'b1;
    endcase
  endfunction : perm_ok

  // legality of a transfer: pattern, mode, location and opcode
  function automatic logic cop_ok(mts_cop_req_t c);
    logic [2:0] o;
    logic ok;
    o = c.instr[`MTS_I_OP2];
    ok = c.priv && c.instr[`MTS_I_FIX] == `MTS_FIX_VAL;
    ok = ok && c.instr[`MTS_I_ONES] == `MTS_ONES_VAL;
    ok = ok && c.instr[`MTS_I_BIT4];
    unique case (c.instr[`MTS_I_CRN])
      `MTS_CR_ID: ok = ok && c.instr[`MTS_I_DIR] && o <= `MTS_OP2_ALT;
      `MTS_CR_FSR, `MTS_CR_PID: ok = ok && o <= `MTS_OP2_ALT;
      `MTS_CR_CACHE, `MTS_CR_TLBOP: ok = ok; // op2 names the operation
      `MTS_CR_CTL, `MTS_CR_TTB, `MTS_CR_DAC, `MTS_CR_FAR, `MTS_CR_CLK,
      `MTS_CR_TLK, `MTS_CR_TEST: ok = ok && o == `MTS_OP2_MAIN;
      default: ok = 1'b0; // reserved locations
    endcase
    cop_ok = ok;
  endfunction : cop_ok

  ////////////////////////////////////////////////////////////////////
  // lookup on the held modified address
  always_comb begin
    hit = 1'b0;
    hidx = '0;
    for (int i = 0; i < TLB_N; i++) begin
      if (q.translation_lookaside_buffer[i].vld &&
          ((q.translation_lookaside_buffer[i].vbase ^ q.modified_virtual_address) & ~size_mask(q.translation_lookaside_buffer[i].kind)) == '0)
      begin
        hit = 1'b1;
        hidx = IW'(i);
      end
    end
    ent = q.translation_lookaside_buffer[hidx];
    dacc = q.dac[{ent.dom, 1'b0} +: 2];
    unique case (q.size)
      `MTS_SZ_WORD: align_bad = q.modified_virtual_address[1:0] != 2'b00;
      `MTS_SZ_HALF: align_bad = q.modified_virtual_address[0];
      default: align_bad = 1'b0;
    endcase
    align_bad = align_bad && !q.fetch && q.ctl[`MTS_CTL_ALIGN];
    // after a wrap the victim restarts at the lock base, skipping the entries below it
    nvic = q.vic + 1'b1;
    if (nvic == '0) begin
      nvic = q.tlk[`MTS_TLK_LSB +: IW];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state: register transfers first, then translation
  always_comb begin
    n = q;
    n.cop_done = 1'b0;
    n.acc_done = 1'b0;
    flt = 1'b0;
    fcode = `MTS_FS_ALIGN;
    fdom = `MTS_NO_DOM;
    target_coproc_register = i_cop.instr[`MTS_I_CRN];
    auxiliary_coproc_field = i_cop.instr[`MTS_I_CRM];
    op2 = i_cop.instr[`MTS_I_OP2];
    // transfers answer one cycle after the request
    if (i_cop_valid) begin
      n.cop_done = 1'b1;
      n.cop_undef = !cop_ok(i_cop);
      n.cop_rdata = '0;
      if (cop_ok(i_cop) && i_cop.instr[`MTS_I_DIR]) begin
        unique case (target_coproc_register)
          `MTS_CR_ID: n.cop_rdata = op2 == `MTS_OP2_ALT ? CTYPE_VAL
                                                       : ID_VAL;
          `MTS_CR_CTL: n.cop_rdata = q.ctl;
          `MTS_CR_TTB: n.cop_rdata = q.ttb;
          `MTS_CR_DAC: n.cop_rdata = q.dac;
          `MTS_CR_FSR: n.cop_rdata = op2 == `MTS_OP2_ALT ? q.ifs : q.dfs;
          `MTS_CR_FAR: n.cop_rdata = q.far;
          `MTS_CR_CLK: n.cop_rdata = auxiliary_coproc_field == `MTS_CRM_INSTRUCTION_CACHE ? q.ilk
                                                          : q.dlk;
          `MTS_CR_TLK: n.cop_rdata = q.tlk;
          `MTS_CR_PID: n.cop_rdata = op2 == `MTS_OP2_ALT ? q.cid : q.pid;
          `MTS_CR_TEST: n.cop_rdata = q.tst;
          default: n.cop_rdata = '0; // operation locations read zero
        endcase
      end else if (cop_ok(i_cop)) begin
        unique case (target_coproc_register)
          `MTS_CR_CTL: n.ctl = i_cop.wdata;
          `MTS_CR_TTB: n.ttb = i_cop.wdata;
          `MTS_CR_DAC: n.dac = i_cop.wdata;
          `MTS_CR_FSR: begin
            if (op2 == `MTS_OP2_ALT) begin
              n.ifs = i_cop.wdata;
            end else begin
              n.dfs = i_cop.wdata;
            end
          end
          `MTS_CR_FAR: n.far = i_cop.wdata;
          // any write here invalidates the whole buffer, locked or not
          `MTS_CR_TLBOP: begin
            for (int i = 0; i < TLB_N; i++) begin
              n.translation_lookaside_buffer[i].vld = 1'b0;
            end
          end
          `MTS_CR_CLK: begin
            if (auxiliary_coproc_field == `MTS_CRM_INSTRUCTION_CACHE) begin
              n.ilk = i_cop.wdata;
            end else begin
              n.dlk = i_cop.wdata;
            end
          end
          `MTS_CR_TLK: n.tlk = i_cop.wdata;
          `MTS_CR_PID: begin
            if (op2 == `MTS_OP2_ALT) begin
              n.cid = i_cop.wdata;
            end else begin
              n.pid = i_cop.wdata & `MTS_PID_MSK;
            end
          end
          `MTS_CR_TEST: n.tst = i_cop.wdata;
          default: n.tst = q.tst; // cache operations: no cache here
        endcase
      end
    end
    unique case (q.st)
      MTS_IDLE: begin
        if (i_acc_valid) begin
          n.modified_virtual_address = i_acc.va;
          if (i_acc.va[`MTS_PID_F] == `MTS_PID_ZERO) begin
            n.modified_virtual_address[`MTS_PID_F] = q.pid[`MTS_PID_F];
          end
          n.fetch = i_acc.fetch;
          n.write = i_acc.write;
          n.priv = i_acc.priv;
          n.size = i_acc.size;
          n.acc_busy = 1'b1;
          n.st = MTS_LOOK;
        end
      end
      MTS_LOOK: begin
        if (align_bad) begin
          flt = 1'b1;
        end else if (!q.ctl[`MTS_CTL_MMU]) begin
          n.acc_done = 1'b1; // flat map, no checks
          n.acc_abort = 1'b0;
          n.acc_pa = q.modified_virtual_address;
          n.acc_busy = 1'b0;
          n.st = MTS_IDLE;
        end else if (hit) begin
          fdom = ent.dom;
          if (dacc != `MTS_DA_CLIENT && dacc != `MTS_DA_MGR) begin
            flt = 1'b1;
            fcode = ent.kind == MTS_SECT ? `MTS_FS_DOM_S : `MTS_FS_DOM_P;
          end else if (dacc == `MTS_DA_CLIENT &&
                       !perm_ok(ap_sel(ent, q.modified_virtual_address), q.priv, q.write)) begin
            flt = 1'b1;
            fcode = ent.kind == MTS_SECT ? `MTS_FS_PERM_S
                                         : `MTS_FS_PERM_P;
          end else begin
            n.acc_done = 1'b1;
            n.acc_abort = 1'b0;
            n.acc_pa = (ent.pbase & ~size_mask(ent.kind)) |
                       (q.modified_virtual_address & size_mask(ent.kind));
            n.acc_busy = 1'b0;
            n.st = MTS_IDLE;
          end
        end else begin
          n.wlk_req = 1'b1;
          n.wlk_addr = {q.ttb[`MTS_TTB_BASE], q.modified_virtual_address[`MTS_MVA_L1],
                        `MTS_WORD_PAD};
          n.st = MTS_WALK1;
        end
      end
      MTS_WALK1: begin
        if (i_wlk_ack) begin
          n.wlk_req = 1'b0;
          n.l1d = i_wlk_data;
          unique case (i_wlk_data[`MTS_D_TYPE])
            `MTS_D_FAULT: begin
              flt = 1'b1;
              fcode = `MTS_FS_TRANS_S;
            end
            `MTS_D_SECT: begin
              n.translation_lookaside_buffer[q.vic] = mk_ent(MTS_SECT, i_wlk_data, q.modified_virtual_address,
                                    i_wlk_data[`MTS_D_DOM]);
              n.vic = nvic;
              n.st = MTS_LOOK;
            end
            `MTS_D_COARSE: begin
              n.wlk_req = 1'b1;
              n.wlk_addr = {i_wlk_data[`MTS_D_CBASE],
                            q.modified_virtual_address[`MTS_MVA_CIDX], `MTS_WORD_PAD};
              n.st = MTS_WALK2;
            end
            `MTS_D_FINE: begin
              n.wlk_req = 1'b1;
              n.wlk_addr = {i_wlk_data[`MTS_D_FBASE],
                            q.modified_virtual_address[`MTS_MVA_FIDX], `MTS_WORD_PAD};
              n.st = MTS_WALK2;
            end
          endcase
        end
      end
      MTS_WALK2: begin
        if (i_wlk_ack) begin
          n.wlk_req = 1'b0;
          fdom = q.l1d[`MTS_D_DOM];
          // a tiny page in a coarse table is a translation fault
          if (i_wlk_data[`MTS_D_TYPE] == `MTS_D_FAULT ||
              (i_wlk_data[`MTS_D_TYPE] == `MTS_P_TINY &&
               q.l1d[`MTS_D_TYPE] == `MTS_D_COARSE)) begin
            flt = 1'b1;
            fcode = `MTS_FS_TRANS_P;
          end else begin
            n.translation_lookaside_buffer[q.vic] = mk_ent(
              i_wlk_data[`MTS_D_TYPE] == `MTS_P_LARGE ? MTS_LARGE :
              i_wlk_data[`MTS_D_TYPE] == `MTS_P_SMALL ? MTS_SMALL :
              MTS_TINY, i_wlk_data, q.modified_virtual_address, fdom);
            n.vic = nvic;
            n.st = MTS_LOOK;
          end
        end
      end
    endcase
    // fault capture sits last so it wins over a same-cycle register write
    if (flt) begin
      if (q.fetch) begin
        n.ifs = {24'h00_0000, fdom, fcode};
      end else begin
        n.dfs = {24'h00_0000, fdom, fcode};
        n.far = q.modified_virtual_address;
      end
      n.acc_done = 1'b1;
      n.acc_abort = 1'b1;
      n.acc_busy = 1'b0;
      n.st = MTS_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register, everything clears to zero
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_cop_done = q.cop_done;
  assign o_cop_undef = q.cop_undef;
  assign o_cop_rdata = q.cop_rdata;
  assign o_acc_busy = q.acc_busy;
  assign o_acc_done = q.acc_done;
  assign o_acc_abort = q.acc_abort;
  assign o_acc_pa = q.acc_pa;
  assign o_wlk_req = q.wlk_req;
  assign o_wlk_addr = q.wlk_addr;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_sect_ack;
    q.st == MTS_WALK1 && i_wlk_ack &&
      i_wlk_data[`MTS_D_TYPE] == `MTS_D_SECT;
  endsequence
  // coarse and fine pointers both lead to a second-level fetch
  sequence s_page_ack;
    q.st == MTS_WALK1 && i_wlk_ack &&
      i_wlk_data[`MTS_D_TYPE] inside {`MTS_D_COARSE, `MTS_D_FINE};
  endsequence

  a_user_refused:
  assert property (i_cop_valid && !i_cop.priv |=> o_cop_done && o_cop_undef)
    else $error("user mode transfer not refused");
  a_bad_pattern:
  assert property (i_cop_valid && i_cop.instr[`MTS_I_FIX] != `MTS_FIX_VAL
                   |=> o_cop_done && o_cop_undef)
    else $error("bad transfer pattern accepted");
  a_pid_remap:
  assert property (q.st == MTS_IDLE && i_acc_valid &&
                   i_acc.va[`MTS_PID_F] == `MTS_PID_ZERO
                   |=> q.modified_virtual_address[`MTS_PID_F] == $past(q.pid[`MTS_PID_F]))
    else $error("process id not applied");
  a_l1_address:
  assert property (q.st == MTS_LOOK && q.ctl[`MTS_CTL_MMU] && !hit &&
                   !align_bad |=> o_wlk_req && o_wlk_addr ==
                   {$past(q.ttb[`MTS_TTB_BASE]), q.modified_virtual_address[`MTS_MVA_L1],
                    `MTS_WORD_PAD})
    else $error("first-level fetch address wrong");
  a_sect_one_fetch:
  assert property (s_sect_ack |=> !o_wlk_req && q.st == MTS_LOOK
                   ##1 o_acc_done && !o_wlk_req)
    else $error("section walk not finished after one fetch");
  a_page_two_fetch:
  assert property (s_page_ack |=> o_wlk_req && q.st == MTS_WALK2)
    else $error("page walk missing second fetch");
  a_hit_answer:
  assert property (q.st == MTS_LOOK && q.ctl[`MTS_CTL_MMU] && hit
                   |=> o_acc_done && !o_acc_busy)
    else $error("hit not answered next cycle");
  a_data_fault_addr:
  assert property (o_acc_done && o_acc_abort && !q.fetch |-> q.far == q.modified_virtual_address)
    else $error("data fault address not captured");
  a_align_abort:
  assert property (q.st == MTS_LOOK && align_bad
                   |=> o_acc_abort && q.dfs[3:0] == `MTS_FS_ALIGN)
    else $error("alignment fault not reported");
endmodule : mts_mmu_top

// >>> test/mts_tbl_mem.sv
// table memory model that answers the walk fetches
`timescale 1ns/1ns
module mts_tbl_mem (
  input wire logic i_core_clk, // core clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_req, // fetch request level
  input wire logic [31:0] i_addr, // fetch address
  input wire logic [3:0] i_dly, // extra wait cycles
  output logic o_ack, // data valid pulse
  output logic [31:0] o_data // descriptor word
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt;
  ////////////////////////////////////////
  // one pulse per held request; data churns outside it so a stale
  // word can never pass for a fresh one, unmapped words read as fault
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 1'b0;
      o_data <= 32'h0;
      cnt <= 4'h0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
    end else if (i_req && cnt >= i_dly) begin
      o_ack <= 1'b1;
      o_data <= mem.exists(i_addr) ? mem[i_addr] : 32'h0;
      cnt <= 4'h0;
    end else begin
      o_data <= ~o_data;
      cnt <= i_req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : mts_tbl_mem

// >>> test/mts_mmu_top_bench.sv
// self-checking bench for the translation and system control block
`timescale 1ns/1ns
module mts_mmu_top_bench;
  import mts_pkg::*;
  logic clk = 0, rst_n = 0, cv = 0, av = 0, ud;
  mts_cop_req_t cq = '0;
  mts_acc_req_t aq = '0;
  logic cd, cu, ab, ad, abt, wr, ak;
  logic [31:0] crd, pa, wa, wd, rd, wl, v;
  logic [3:0] dly = 4'h0;
  logic [3:0] ns [4] = '{4'h2, 4'h3, 4'h6, 4'hf};
  int n_fail = 0, checked = 0, lat, nw;
  int sh [16];
  always #5 clk = ~clk;
  mts_mmu_top #(.ID_VAL(32'h1234_abcd), .CTYPE_VAL(32'h0000_00aa)) dut (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_cop_valid(cv), .i_cop(cq),
    .o_cop_done(cd), .o_cop_undef(cu), .o_cop_rdata(crd),
    .i_acc_valid(av), .i_acc(aq), .o_acc_busy(ab), .o_acc_done(ad),
    .o_acc_abort(abt), .o_acc_pa(pa), .o_wlk_req(wr), .o_wlk_addr(wa),
    .i_wlk_ack(ak), .i_wlk_data(wd));
  mts_tbl_mem mem (.i_core_clk(clk), .i_arst_n(rst_n), .i_req(wr),
    .i_addr(wa), .i_dly(dly), .o_ack(ak), .o_data(wd));
  ////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // one transfer; the answer is registered on the taking edge and checked just after it
  task cop(input logic l, input logic [3:0] n, input logic [2:0] o,
      input logic [3:0] m, input logic [31:0] d, input logic p,
      input logic [31:0] bad);
    @(posedge clk) #1;
    cq = '{{8'hee, 3'h0, l, n, 8'h0f, o, 1'b1, m} ^ bad, d, p};
    cv = 1;
    @(posedge clk) #1;
    cv = 0;
    chk({31'h0, cd}, 32'h1);
    rd = crd;
    ud = cu;
  endtask : cop
  task wrc(input logic [3:0] n, input logic [2:0] o, input logic [31:0] d);
    cop(0, n, o, 4'h0, d, 1, 0);
    chk({31'h0, ud}, 32'h0);
  endtask : wrc
  task rdc(input logic [3:0] n, input logic [2:0] o, input logic [31:0] m,
      input logic [31:0] e);
    cop(1, n, o, 4'h0, 0, 1, 0);
    chk(rd & m, e);
  endtask : rdc
  // one word access; counts edges to the answer and table fetches
  task acc(input logic [31:0] a, input logic f, input logic w,
      input logic p);
    @(posedge clk) #1;
    aq = '{a, f, w, p, 2'h2};
    av = 1;
    @(posedge clk) #1;
    av = 0;
    chk({31'h0, ab}, 32'h1);
    nw = 0;
    lat = 0;
    while (ad !== 1'b1) begin
      if (lat == 60) begin
        n_fail++;
        stop_test();
      end
      @(posedge clk) #1;
      lat++;
      if (ak === 1'b1) begin
        nw++;
        wl = wa;
        chk({31'h0, wr}, 32'h1);
      end
    end
    chk({31'h0, ab}, 32'h0);
    chk({31'h0, wr}, 32'h0);
  endtask : acc
  task ex(input logic e, input logic [31:0] p, input int n);
    chk({31'h0, abt}, {31'h0, e});
    if (!e)
      chk(pa, p);
    chk(32'(nw), 32'(n));
  endtask : ex
  ////////////////////////////////////////
  // registers first, then translation through the walk partner
  initial begin
    void'($urandom(32'h40ce7dbe));
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    foreach (ns[i]) begin
      sh[ns[i]] = $urandom & (ns[i] == 4'h2 ? 32'hffffc000 : 32'hffffffff);
      wrc(ns[i], 0, sh[ns[i]]);
      rdc(ns[i], 0, '1, sh[ns[i]]);
    end
    rdc(0, 0, '1, 32'h1234_abcd);
    rdc(0, 1, '1, 32'h0000_00aa);
    wrc(13, 0, 32'hffff_ffff);
    rdc(13, 0, '1, 32'hfe00_0000);
    v = $urandom;
    wrc(13, 1, v);
    rdc(13, 1, '1, v);
    cop(0, 9, 0, 1, 32'h0000_0011, 1, 0);
    cop(0, 9, 0, 0, 32'h0000_0022, 1, 0);
    cop(1, 9, 0, 1, 0, 1, 0);
    chk(rd, 32'h0000_0011);
    rdc(9, 0, '1, 32'h0000_0022);
    rdc(8, 0, '1, 0);
    cop(1, 4, 0, 0, 0, 1, 0);
    chk({31'h0, ud}, 1);
    cop(0, 0, 0, 0, 0, 1, 0);
    chk({31'h0, ud}, 1);
    cop(1, 1, 2, 0, 0, 1, 0);
    chk({31'h0, ud}, 1);
    cop(0, 6, 0, 0, $urandom, 0, 0);
    chk({31'h0, ud}, 1);
    cop(1, 6, 0, 0, 0, 1, 32'h0000_0010);
    chk({31'h0, ud}, 1);
    cop(1, 6, 0, 0, 0, 1, 32'h0100_0100);
    chk({31'h0, ud}, 1);
    rdc(6, 0, '1, sh[6]);
    // translation off: process id remap and data-only alignment check
    wrc(13, 0, 32'h0600_0000);
    wrc(1, 0, 32'h2);
    acc(32'h0012_3454, 0, 0, 1);
    ex(0, 32'h0612_3454, 0);
    acc(32'h0012_3455, 0, 0, 1);
    ex(1, 0, 0);
    rdc(5, 0, 32'hf, 32'h1);
    rdc(6, 0, '1, 32'h0612_3455);
    acc(32'h0012_3455, 1, 0, 1);
    ex(0, 32'h0612_3455, 0);
    // translation on: sections, pages, domains, faults
    mem.mem[32'h448c] = 32'h8000_0c42;
    mem.mem[32'h48d0] = 32'h0001_0041;
    mem.mem[32'h0001_0014] = 32'h9abc_df72;
    mem.mem[32'h4d14] = 32'h8010_0c22;
    mem.mem[32'h5158] = 32'h8020_0062;
    wrc(13, 0, 0);
    wrc(2, 0, 32'h0000_4000);
    wrc(3, 0, 32'h0000_00d0);
    wrc(1, 0, 32'h1);
    dly = 4'h3;
    acc(32'h1230_0abc, 0, 0, 1);
    ex(0, 32'h8000_0abc, 1);
    chk(wl, 32'h448c);
    dly = 4'h0;
    acc(32'h1230_0ff0, 0, 1, 0);
    ex(0, 32'h8000_0ff0, 0);
    chk(32'(lat), 1);
    acc(32'h2340_5678, 0, 0, 1);
    ex(0, 32'h9abc_d678, 2);
    chk(wl, 32'h0001_0014);
    acc(32'h2340_5678, 0, 0, 0);
    ex(1, 0, 0);
    rdc(5, 0, 32'hff, 32'h2f);
    rdc(6, 0, '1, 32'h2340_5678);
    acc(32'h2340_5278, 0, 0, 0);
    ex(0, 32'h9abc_d278, 0);
    acc(32'h3450_0000, 0, 0, 1);
    ex(1, 0, 1);
    rdc(5, 0, 32'hff, 32'h19);
    acc(32'h4560_0010, 0, 1, 0);
    ex(0, 32'h8020_0010, 1);
    acc(32'h5670_0000, 1, 0, 1);
    ex(1, 0, 1);
    rdc(5, 1, 32'hff, 32'h05);
    rdc(5, 0, 32'hff, 32'h19);
    rdc(6, 0, '1, 32'h3450_0000);
    wrc(8, 0, $urandom);
    acc(32'h1230_0000, 0, 0, 1);
    ex(0, 32'h8000_0000, 1);
    // fine table: tiny page with one permission set, then a large page
    mem.mem[32'h59e0] = 32'h0002_0043;
    mem.mem[32'h0002_012c] = 32'h7654_3823;
    mem.mem[32'h0002_010c] = 32'h1111_0031;
    acc(32'h6781_2c34, 0, 0, 0);
    ex(0, 32'h7654_3834, 2);
    acc(32'h6781_2c34, 0, 1, 0);
    ex(1, 0, 0);
    rdc(5, 0, 32'hff, 32'h2f);
    rdc(6, 0, '1, 32'h6781_2c34);
    acc(32'h6781_0c34, 0, 1, 0);
    ex(0, 32'h1111_0c34, 2);
    stop_test();
  end
endmodule : mts_mmu_top_bench
